// ==== mwd_watchdog.sv ====
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
// Contract
// - Countdown steps once per 1 ms tick.
// - Timeout spans 1 to 65535 ms through a 16-bit field.
// - Counter runs only in full power state; otherwise it holds.
// - Bad inverse half gets a NACK; a good word is stored and ACKed.
// - Countdown expiry while enabled pulses the tile reset.
// - Software kicks periodically; each accepted kick restarts the count.
// - Live count reads in control bits 31:16, zero after reset.
// - Timeout sits in control bits 15:0, resets to 1000.
// - Writing zero to the key register enables counting.
// - Writing the disable code clears and stops the counter.
// - Key register resets to the disable code; watchdog off.
// - Tick derives from the clock using the programmed MHz figure.
module mwd_watchdog #(
	parameter logic [mwd_pkg::US_W-1:0] US_PER_TICK =
		mwd_pkg::US_W'(mwd_pkg::TICK_US)
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        clkEn,
	input  wire logic        fullPowerState,
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdData,
	output logic             wrAck,
	output logic             wrNack,
	output logic             tileReset
);
	mwd_tick_if tk ();

	mwd_pkg::mwd_state_e             state_q;
	logic [mwd_pkg::CNT_W-1:0]       count_q;
	logic [mwd_pkg::CNT_W-1:0]       timeout_q;
	logic [mwd_pkg::DATA_W-1:0]      key_q;
	logic [mwd_pkg::FREQ_W-1:0]      freq_q;
	logic [mwd_pkg::DATA_W-1:0]      rdData_q;
	logic                            wrAck_q;
	logic                            wrNack_q;
	logic                            tileReset_q;

	logic                            wrCtrl;
	logic                            wrKey;
	logic                            wrFreq;
	logic                            ctrlGood;
	logic                            freqGood;
	logic                            keyEnable;
	logic                            keyDisable;
	logic                            startNow;
	logic                            kickNow;
	logic                            fireNow;
	logic                            isOff;

	// Address match for one register
	function automatic logic hitReg(
		input logic [mwd_pkg::ADDR_W-1:0] a,
		input logic [mwd_pkg::ADDR_W-1:0] off
	);
		return a == off;
	endfunction

	// Upper half must be the exact inverse of the lower half
	function automatic logic complOk(input logic [31:0] w);
		return w[mwd_pkg::LIVE_MSB:mwd_pkg::LIVE_LSB] ==
			~w[mwd_pkg::TMO_MSB:mwd_pkg::TMO_LSB];
	endfunction

	// Frequency word within the accepted MHz range
	function automatic logic freqOk(input logic [31:0] w);
		return w >= mwd_pkg::DATA_W'(mwd_pkg::FREQ_MIN) &&
			w <= mwd_pkg::DATA_W'(mwd_pkg::FREQ_MAX);
	endfunction

	// Write decode
	assign wrCtrl = regWr && hitReg(regAddr, mwd_pkg::OFF_CTRL);
	assign wrKey  = regWr && hitReg(regAddr, mwd_pkg::OFF_KEY);
	assign wrFreq = regWr && hitReg(regAddr, mwd_pkg::OFF_FREQ);
	assign isOff  = (state_q == mwd_pkg::MWD_OFF);

	assign ctrlGood = wrCtrl && complOk(regWrData);
	// Range check on the MHz figure
	assign freqGood = wrFreq && freqOk(regWrData);

	assign keyEnable  = wrKey && (regWrData == mwd_pkg::KEY_ENABLE);
	assign keyDisable = wrKey && (regWrData == mwd_pkg::KEY_DISABLE);

	// Events that restart the countdown
	assign startNow = keyEnable && isOff;
	assign kickNow  = ctrlGood && !isOff;

	// Expiry on the last tick, unless a write overrides it
	assign fireNow = (state_q == mwd_pkg::MWD_RUN) && tk.tick &&
		(count_q <= mwd_pkg::COUNT_LAST) && !keyDisable && !kickNow;

	// Tick source controls
	// Prescaler runs only full_power_state and enabled
	assign tk.freqMhz = freq_q;
	assign tk.run     = (state_q == mwd_pkg::MWD_RUN) && fullPowerState;
	assign tk.restart = startNow || kickNow || keyDisable;

	mwd_tick_gen #(
		.US_PER_TICK (US_PER_TICK)
	) u_tick (
		.clk   (clk),
		.rst_n (rst_n),
		.clkEn (clkEn),
		.tk    (tk)
	);

	// Watchdog state and live count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= mwd_pkg::MWD_OFF;
			count_q <= mwd_pkg::COUNT_RST;
		end else if (clkEn) begin
			if (keyDisable) begin
				state_q <= mwd_pkg::MWD_OFF;
				count_q <= mwd_pkg::COUNT_RST;
			end else if (startNow) begin
				state_q <= mwd_pkg::MWD_RUN;
				count_q <= timeout_q;
			end else if (kickNow) begin
				state_q <= mwd_pkg::MWD_RUN;
				count_q <= regWrData[mwd_pkg::TMO_MSB:mwd_pkg::TMO_LSB];
			end else begin
				case (state_q)
					mwd_pkg::MWD_OFF: begin
						// Other key values keep it off
						state_q <= mwd_pkg::MWD_OFF;
					end
					mwd_pkg::MWD_RUN: begin
						if (fireNow) begin
							state_q <= mwd_pkg::MWD_FIRE;
						end else if (tk.tick) begin
							count_q <= mwd_pkg::CNT_W'(count_q -
								mwd_pkg::COUNT_STEP);
						end
					end
					mwd_pkg::MWD_FIRE: begin
						state_q <= mwd_pkg::MWD_RUN;
						count_q <= timeout_q;
					end
					default: begin
						state_q <= mwd_pkg::MWD_OFF;
						count_q <= mwd_pkg::COUNT_RST;
					end
				endcase
			end
		end
	end

	// Timeout field
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timeout_q <= mwd_pkg::TIMEOUT_RST;
		end else if (clkEn && ctrlGood) begin
			timeout_q <= regWrData[mwd_pkg::TMO_MSB:mwd_pkg::TMO_LSB];
		end
	end

	// Key register, stored whatever is written
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// Key resets to the disable code
			key_q <= mwd_pkg::KEY_DISABLE;
		end else if (clkEn && wrKey) begin
			key_q <= regWrData;
		end
	end

	// Oscillator MHz figure
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			freq_q <= mwd_pkg::FREQ_RST;
		end else if (clkEn && freqGood) begin
			freq_q <= regWrData[mwd_pkg::FREQ_W-1:0];
		end
	end

	// Write answer, one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrAck_q  <= 1'b0;
			wrNack_q <= 1'b0;
		end else if (clkEn) begin
			// ACK good words, NACK the rest
			wrAck_q  <= ctrlGood || wrKey || freqGood;
			wrNack_q <= regWr && !(ctrlGood || wrKey || freqGood);
		end
	end

	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_q <= mwd_pkg::RD_IDLE;
		end else if (clkEn) begin
			if (regRd && hitReg(regAddr, mwd_pkg::OFF_CTRL)) begin
				rdData_q <= {count_q, timeout_q};
			end else if (regRd && hitReg(regAddr, mwd_pkg::OFF_KEY)) begin
				rdData_q <= key_q;
			end else if (regRd && hitReg(regAddr, mwd_pkg::OFF_FREQ)) begin
				rdData_q <= mwd_pkg::DATA_W'(freq_q);
			end else begin
				rdData_q <= mwd_pkg::RD_IDLE;
			end
		end
	end

	// Tile reset pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tileReset_q <= 1'b0;
		end else if (clkEn) begin
			tileReset_q <= fireNow;
		end
	end

	// Outputs straight from flops
	assign regRdData = rdData_q;
	assign wrAck     = wrAck_q;
	assign wrNack    = wrNack_q;
	assign tileReset = tileReset_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Expiry, then the reload cycle
	sequence seqExpire;
		clkEn && fireNow;
	endsequence

	sequence seqFireQuiet;
		clkEn && state_q == mwd_pkg::MWD_FIRE && !regWr;
	endsequence

	AST_BAD_COMPL_NACK: assert property (
		(clkEn && wrCtrl && !complOk(regWrData)) |=>
			wrNack && !wrAck && timeout_q == $past(timeout_q))
		else $error("bad timeout word not refused");
	AST_GOOD_COMPL_ACK: assert property (
		(clkEn && ctrlGood) |=> wrAck && !wrNack &&
			timeout_q == $past(regWrData[15:0]))
		else $error("good timeout word not taken");
	AST_KICK_RELOAD: assert property (
		(clkEn && kickNow) |=> count_q == $past(regWrData[15:0]) &&
			state_q == mwd_pkg::MWD_RUN)
		else $error("kick did not restart the count");
	AST_ENABLE_START: assert property (
		(clkEn && keyEnable && isOff) |=>
			state_q == mwd_pkg::MWD_RUN && count_q == $past(timeout_q))
		else $error("enable code did not start counting");
	AST_DISABLE_CLEAR: assert property (
		(clkEn && keyDisable) |=>
			isOff && count_q == mwd_pkg::COUNT_RST && !tileReset)
		else $error("disable code did not clear and stop");
	AST_OTHER_KEY_KEEP: assert property (
		(clkEn && isOff && wrKey && !keyEnable) |=> isOff)
		else $error("other key value changed the state");
	AST_ASLEEP_HOLD: assert property (
		(clkEn && !fullPowerState && !regWr && !tk.tick &&
			state_q == mwd_pkg::MWD_RUN) |=> $stable(count_q))
		else $error("count moved outside full power state");
	AST_TICK_DECREMENT: assert property (
		(clkEn && tk.tick && !fireNow && !regWr &&
			state_q == mwd_pkg::MWD_RUN) |=>
			count_q == $past(count_q) - mwd_pkg::COUNT_STEP)
		else $error("tick did not step the count by one");
	AST_EXPIRE_RESET: assert property (
		seqExpire |=> tileReset ##1 !tileReset || !clkEn)
		else $error("expiry did not pulse tile reset");
	AST_RELOAD_AFTER: assert property (
		seqExpire ##1 seqFireQuiet |=>
			count_q == $past(timeout_q) && state_q == mwd_pkg::MWD_RUN)
		else $error("count not reloaded after expiry");
	AST_LIVE_READ: assert property (
		(clkEn && regRd && hitReg(regAddr, mwd_pkg::OFF_CTRL)) |=>
			regRdData[31:16] == $past(count_q) &&
			regRdData[15:0] == $past(timeout_q))
		else $error("control read shows wrong fields");
	AST_FREQ_RANGE: assert property (
		freqOk(mwd_pkg::DATA_W'(freq_q)))
		else $error("MHz figure left its valid range");
	AST_READ_ONE_CYCLE: assert property (
		(clkEn && !regRd) |=> regRdData == mwd_pkg::RD_IDLE)
		else $error("read data outside its cycle");

	// Only a good write moves the timeout; each write gets one answer, a quiet cycle none
	AST_TIMEOUT_KEEP: assert property (
		(clkEn && !ctrlGood) |=> $stable(timeout_q))
		else $error("timeout changed without a good write");
	AST_WRITE_ANSWER: assert property (
		(clkEn && regWr) |=> wrAck != wrNack)
		else $error("write got no single answer");
	AST_NO_STRAY_ANSWER: assert property (
		(clkEn && !regWr) |=> !wrAck && !wrNack)
		else $error("answer without a write");

	// Values seen at the first edge after reset release
	AST_RESET_COUNT: assert property (
		$rose(rst_n) |-> count_q == mwd_pkg::COUNT_RST)
		else $error("live count not zero after reset");
	AST_RESET_TIMEOUT: assert property (
		$rose(rst_n) |-> timeout_q == mwd_pkg::TIMEOUT_RST)
		else $error("timeout not at its reset value");
	AST_RESET_KEY: assert property (
		$rose(rst_n) |-> key_q == mwd_pkg::KEY_DISABLE && isOff)
		else $error("watchdog not disabled after reset");

	// Off or asleep, nothing expires; a stray key leaves it running
	AST_OFF_QUIET: assert property (
		(clkEn && isOff) |=> !tk.tick && !tileReset)
		else $error("tick or tile reset while off");
	AST_ASLEEP_NO_TICK: assert property (
		(clkEn && !fullPowerState) |=> !tk.tick)
		else $error("tick raised outside full power state");
	AST_RUN_KEY_KEEP: assert property (
		(clkEn && !isOff && wrKey && !keyEnable && !keyDisable) |=>
			!isOff)
		else $error("other key value stopped the watchdog");
	AST_FIRE_HOLDS_COUNT: assert property (
		seqExpire |=> count_q == $past(count_q))
		else $error("count moved in the expiry cycle");
endmodule

// ==== mwd_pkg.sv ====
package mwd_pkg;
	// Widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W  = 16;
	localparam int FREQ_W = 7;
	localparam int US_W   = 10;

	// Field positions of the control word
	localparam int TMO_LSB  = 0;
	localparam int TMO_MSB  = 15;
	localparam int LIVE_LSB = 16;
	localparam int LIVE_MSB = 31;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFF_FREQ = 8'h51;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'hD6;
	localparam logic [ADDR_W-1:0] OFF_KEY  = 8'hD7;

	// Reset values and codes
	localparam logic [CNT_W-1:0]  TIMEOUT_RST = 16'h03E8;
	localparam logic [CNT_W-1:0]  COUNT_RST   = 16'h0000;
	localparam logic [CNT_W-1:0]  COUNT_LAST  = 16'h0001;
	localparam logic [CNT_W-1:0]  COUNT_STEP  = 16'h0001;
	localparam logic [DATA_W-1:0] KEY_DISABLE = 32'h0D15AB1E;
	localparam logic [DATA_W-1:0] KEY_ENABLE  = 32'h00000000;
	localparam logic [DATA_W-1:0] RD_IDLE     = 32'h00000000;
	localparam logic [FREQ_W-1:0] FREQ_RST    = 7'h19;
	localparam logic [FREQ_W-1:0] FREQ_MIN    = 7'h05;
	localparam logic [FREQ_W-1:0] FREQ_MAX    = 7'h64;
	localparam logic [FREQ_W-1:0] FREQ_STEP   = 7'h01;
	localparam logic [US_W-1:0]   US_STEP     = 10'h001;

	// Tick period, 1 ms, as a count of microseconds
	localparam int TICK_MS   = 1;
	localparam int US_PER_MS = 1000;
	localparam int TICK_US   = TICK_MS * US_PER_MS;

	// Watchdog states
	typedef enum logic [2:0] {
		MWD_OFF  = 3'h1,
		MWD_RUN  = 3'h2,
		MWD_FIRE = 3'h4
	} mwd_state_e;
endpackage

// ==== mwd_tick_if.sv ====
`timescale 1ns/100ps
// Link between the watchdog core and its millisecond tick source
interface mwd_tick_if;
	logic [mwd_pkg::FREQ_W-1:0] freqMhz;
	logic                       run;
	logic                       restart;
	logic                       tick;

	modport core (output freqMhz, output run, output restart, input tick);
	modport gen  (input freqMhz, input run, input restart, output tick);
endinterface

// ==== mwd_tick_gen.sv ====
`timescale 1ns/100ps
// Millisecond tick from the system clock and the programmed MHz figure
module mwd_tick_gen #(
	parameter logic [mwd_pkg::US_W-1:0] US_PER_TICK =
		mwd_pkg::US_W'(mwd_pkg::TICK_US)
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic clkEn,
	mwd_tick_if.gen   tk
);
	logic [mwd_pkg::FREQ_W-1:0] usCnt_q;
	logic [mwd_pkg::US_W-1:0]   msCnt_q;
	logic                       tick_q;
	logic                       usWrap;
	logic                       msWrap;

	// End of one microsecond and of one millisecond
	assign usWrap = (usCnt_q == mwd_pkg::FREQ_W'(tk.freqMhz -
		mwd_pkg::FREQ_STEP));
	assign msWrap = (msCnt_q == mwd_pkg::US_W'(US_PER_TICK -
		mwd_pkg::US_STEP));
	assign tk.tick = tick_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			usCnt_q <= '0;
			msCnt_q <= '0;
		end else if (clkEn) begin
			if (tk.restart) begin
				usCnt_q <= '0;
				msCnt_q <= '0;
			end else if (tk.run) begin
				if (usWrap) begin
					usCnt_q <= '0;
					msCnt_q <= msWrap ? '0 :
						mwd_pkg::US_W'(msCnt_q + mwd_pkg::US_STEP);
				end else begin
					usCnt_q <= mwd_pkg::FREQ_W'(usCnt_q + mwd_pkg::FREQ_STEP);
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_q <= 1'b0;
		end else if (clkEn) begin
			tick_q <= tk.run && !tk.restart && usWrap && msWrap;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_TICK_NEEDS_RUN: assert property (
		$rose(tick_q) |-> $past(tk.run))
		else $error("tick raised while not running");
	AST_TICK_SINGLE: assert property (
		(clkEn && tick_q && tk.freqMhz >= mwd_pkg::FREQ_MIN) |=> !tick_q)
		else $error("tick longer than one cycle");
endmodule

// ==== mwd_tb.sv ====
`timescale 1ns/100ps
module tb;
	localparam logic [9:0] US_TB = 10'h004;
	localparam logic [7:0] OFF_NONE = 8'h40;
	logic        clk;
	logic        rst_n;
	logic        clkEn;
	logic        fullPowerState;
	logic [7:0]  regAddr;
	logic [31:0] regWrData;
	logic        regWr;
	logic        regRd;
	logic [31:0] regRdData;
	logic        wrAck;
	logic        wrNack;
	logic        tileReset;
	logic        wasHigh = 1'b0;
	logic [31:0] rd;
	logic [31:0] keep;
	int          n_mismatch = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          nPulse = 0;
	int          lastPulse = 0;
	int          prevPulse = 0;
	int          base;

	mwd_watchdog #(.US_PER_TICK(US_TB)) i_mwd_watchdog (
		.clk           (clk),
		.rst_n         (rst_n),
		.clkEn         (clkEn),
		.fullPowerState(fullPowerState),
		.regAddr       (regAddr),
		.regWrData     (regWrData),
		.regWr         (regWr),
		.regRd         (regRd),
		.regRdData     (regRdData),
		.wrAck         (wrAck),
		.wrNack        (wrNack),
		.tileReset     (tileReset)
	);

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Tile reset pulses, their spacing and width; hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		wasHigh <= tileReset;
		if (tileReset === 1'b1) begin
			check("reset width", {31'h0, wasHigh}, 32'h0);
			nPulse <= nPulse + 1;
			prevPulse <= lastPulse;
			lastPulse <= cyc;
		end
		if (cyc == 5000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// One write cycle, answer judged the cycle after
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic good);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		#1;
		check("write answer", {30'h0, wrAck, wrNack},
			good ? 32'h00000002 : 32'h00000001);
	endtask

	// One read cycle, data taken the cycle after
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		rd = regRdData;
		check("read data", rd, exp);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wait_pulse(input int target, input int limit);
		for (int i = 0; i < limit && nPulse < target; i++) begin
			@(posedge clk);
			#1;
		end
	endtask

	task automatic test_reset;
		rdc(mwd_pkg::OFF_CTRL, 32'h000003E8);
		rdc(mwd_pkg::OFF_KEY, 32'h0D15AB1E);
		rdc(mwd_pkg::OFF_FREQ, 32'h00000019);
		rdc(OFF_NONE, 32'h00000000);
		$display("test reset done");
	endtask

	task automatic test_freq;
		wr(mwd_pkg::OFF_FREQ, 32'h00000004, 1'b0);
		wr(mwd_pkg::OFF_FREQ, 32'h00000065, 1'b0);
		rdc(mwd_pkg::OFF_FREQ, 32'h00000019);
		wr(mwd_pkg::OFF_FREQ, 32'h00000005, 1'b1);
		rdc(mwd_pkg::OFF_FREQ, 32'h00000005);
		wr(OFF_NONE, 32'h00000005, 1'b0);
		$display("test freq done");
	endtask

	task automatic test_timeout;
		wr(mwd_pkg::OFF_CTRL, 32'hFFFF0001, 1'b0);
		rdc(mwd_pkg::OFF_CTRL, 32'h000003E8);
		wr(mwd_pkg::OFF_CTRL, 32'hFFFE0001, 1'b1);
		rdc(mwd_pkg::OFF_CTRL, 32'h00000001);
		wr(mwd_pkg::OFF_CTRL, 32'h0000FFFF, 1'b1);
		rdc(mwd_pkg::OFF_CTRL, 32'h0000FFFF);
		check("pulses while off", nPulse, 32'h00000000);
		$display("test timeout done");
	endtask

	task automatic test_expiry;
		wr(mwd_pkg::OFF_CTRL, 32'hFFFC0003, 1'b1);
		wr(mwd_pkg::OFF_KEY, 32'h00000000, 1'b1);
		rdc(mwd_pkg::OFF_CTRL, 32'h00030003);
		idle(28);
		rdc(mwd_pkg::OFF_CTRL, 32'h00020003);
		wait_pulse(2, 200);
		check("pulse count", nPulse, 32'h00000002);
		// Three 20-cycle ticks plus the reload cycle
		check("expiry spacing", 32'(lastPulse - prevPulse),
			32'h0000003D);
		$display("test expiry done");
	endtask

	task automatic test_kick;
		base = nPulse;
		repeat (8) begin
			wr(mwd_pkg::OFF_CTRL, 32'hFFFC0003, 1'b1);
			idle(36);
		end
		check("pulses with kicks", nPulse, base);
		$display("test kick done");
	endtask

	task automatic test_power;
		@(posedge clk);
		fullPowerState <= 1'b0;
		base = nPulse;
		idle(2);
		wr(mwd_pkg::OFF_CTRL, 32'hFFFC0003, 1'b1);
		idle(30);
		rdc(mwd_pkg::OFF_CTRL, 32'h00030003);
		keep = rd;
		idle(150);
		rdc(mwd_pkg::OFF_CTRL, keep);
		check("pulses asleep", nPulse, base);
		@(posedge clk);
		fullPowerState <= 1'b1;
		$display("test power done");
	endtask

	task automatic test_key;
		wr(mwd_pkg::OFF_KEY, 32'h12345678, 1'b1);
		rdc(mwd_pkg::OFF_KEY, 32'h12345678);
		base = nPulse;
		wait_pulse(base + 1, 100);
		check("still running", nPulse, base + 1);
		wr(mwd_pkg::OFF_KEY, 32'h0D15AB1E, 1'b1);
		rdc(mwd_pkg::OFF_CTRL, 32'h00000003);
		base = nPulse;
		idle(150);
		check("pulses disabled", nPulse, base);
		rdc(mwd_pkg::OFF_CTRL, 32'h00000003);
		$display("test key done");
	endtask

	// Clock enable low freezes a running countdown
	task automatic test_freeze;
		wr(mwd_pkg::OFF_KEY, 32'h00000000, 1'b1);
		base = nPulse;
		@(posedge clk);
		clkEn <= 1'b0;
		idle(100);
		clkEn <= 1'b1;
		rdc(mwd_pkg::OFF_CTRL, 32'h00030003);
		check("pulses frozen", nPulse, base);
		wait_pulse(base + 1, 100);
		check("pulse after thaw", nPulse, base + 1);
		wr(mwd_pkg::OFF_KEY, 32'h0D15AB1E, 1'b1);
		$display("test freeze done");
	endtask

	// Reset, then the scenarios in order
	initial begin
		rst_n = 1'b0;
		clkEn = 1'b1;
		fullPowerState = 1'b1;
		regAddr = 8'h00;
		regWrData = 32'h00000000;
		regWr = 1'b0;
		regRd = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		test_reset();
		test_freq();
		test_timeout();
		test_expiry();
		test_kick();
		test_power();
		test_key();
		test_freeze();
		tally_and_finish();
	end
endmodule
